//--- rtl/acp_top.v
// Converter control top: register port, result rounding, compare,
// conversion-complete flag, pin disables and converter clocking.
// Assumes a synchronous analog core and port logic on clk.
// Pin registers exist only where the variant has analog inputs.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.vh"

module acp_top #(
  parameter HAS_MID_PINS = 1,
  parameter HAS_HIGH_PINS = 1,
  parameter RAW_BITS = `ACP_RAW_BITS
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Power mode and foreign clocks
  input wire low_power_mode,
  input wire alternate_clock,
  input wire internal_async_clock,
  // Analog core
  input wire comparator_high,
  output wire [RAW_BITS-1:0] trial_code,
  output wire sample_enable,
  output wire [4:0] analog_channel,
  output wire converter_power_on,
  output wire async_clock_enable,
  // Interrupt request and compare result
  output wire done_irq,
  output wire compare_match,
  // Port logic for channels 8 to 23
  input wire [15:0] port_pin_in,
  input wire [15:0] port_out_en_n_in,
  input wire [15:0] port_pullup_in,
  output wire [15:0] port_read_value,
  output wire [15:0] pin_out_en_n,
  output wire [15:0] pin_pullup_en,
  output wire [15:0] pin_input_en
);

  reg [4:0] channel_select_q;
  reg done_interrupt_enable_q;
  reg conversion_done_flag_q;
  reg compare_enable_q;
  reg compare_match_q;
  reg [1:0] input_clock_select_q;
  reg [1:0] clock_divide_select_q;
  reg [1:0] mode_q;
  reg [7:0] compare_high_q;
  reg [7:0] compare_low_q;
  reg [7:0] result_high_q;
  reg [7:0] result_low_q;
  reg [7:0] analog_pin_disable_mid_q;
  reg [7:0] analog_pin_disable_high_q;
  reg start_q;
  reg [7:0] rdata_d;

  wire wr_control;
  wire wr_setup;
  wire rd_result_low;
  wire module_off;
  wire ten_bit;
  wire run;
  wire converter_clock;
  wire sar_done;
  wire sar_busy;
  wire [9:0] rounded;
  wire [9:0] compare_value;
  wire accept;
  wire [15:0] pin_off;
  wire sar_sample_w;

  // Round a left-aligned raw code to the mode's width, saturating at top
  function [9:0] acp_round;
    input [RAW_BITS-1:0] raw;
    input wide;
    reg [10:0] sum;
    begin
      sum = 11'h000;
      if (wide) begin
        sum = {1'b0, raw[10:1]} + {10'h000, raw[0]};
        if (sum[10])
          sum = 11'h3FF;
      end else begin
        sum = {3'h0, raw[10:3]} + {10'h000, raw[2]};
        if (sum[8])
          sum = 11'h0FF;
      end
      acp_round = sum[9:0];
    end
  endfunction

  // Decode of register writes and reads
  assign wr_control = reg_write && (reg_addr == `ACP_OFF_CONTROL);
  assign wr_setup = reg_write && ((reg_addr == `ACP_OFF_STATUS) ||
    (reg_addr == `ACP_OFF_CONFIG) ||
    (reg_addr == `ACP_OFF_COMPARE_HIGH) ||
    (reg_addr == `ACP_OFF_COMPARE_LOW));
  assign rd_result_low = reg_read && (reg_addr == `ACP_OFF_RESULT_LOW);

  // Module is held off in reset or with the all-ones channel
  assign module_off = (channel_select_q == `ACP_CH_DISABLED);

  // Mode bit one decides width; reserved codes follow that bit
  assign ten_bit = mode_q[1];

  // Converter powered only while a conversion runs
  assign run = sar_busy && !module_off;
  assign converter_power_on = run;
  assign async_clock_enable = run &&
    (input_clock_select_q == `ACP_CLK_ASYNC);

  // Channel and sample phase handed to the analog core
  assign analog_channel = channel_select_q;
  assign sample_enable = sar_sample_w;

  // Control and setup registers
  always @(posedge clk) begin
    if (reset) begin
      channel_select_q <= `ACP_RST_CHANNEL;
      done_interrupt_enable_q <= 1'b0;
      compare_enable_q <= 1'b0;
      input_clock_select_q <= `ACP_CLK_BUS;
      clock_divide_select_q <= 2'h0;
      mode_q <= `ACP_MODE_8BIT;
      compare_high_q <= `ACP_RST_BYTE;
      compare_low_q <= `ACP_RST_BYTE;
      start_q <= 1'b0;
    end else begin
      // A control write with a live channel starts a conversion
      start_q <= wr_control &&
        (reg_wdata[`ACP_CTL_CH_MSB:`ACP_CTL_CH_LSB] != `ACP_CH_DISABLED);
      if (wr_control) begin
        channel_select_q <= reg_wdata[`ACP_CTL_CH_MSB:`ACP_CTL_CH_LSB];
        done_interrupt_enable_q <= reg_wdata[`ACP_CTL_IEN_BIT];
      end
      if (reg_write && reg_addr == `ACP_OFF_STATUS)
        compare_enable_q <= reg_wdata[`ACP_STS_CMPEN_BIT];
      if (reg_write && reg_addr == `ACP_OFF_CONFIG) begin
        input_clock_select_q <=
          reg_wdata[`ACP_CFG_CLK_MSB:`ACP_CFG_CLK_LSB];
        clock_divide_select_q <=
          reg_wdata[`ACP_CFG_DIV_MSB:`ACP_CFG_DIV_LSB];
        mode_q <= reg_wdata[`ACP_CFG_MODE_MSB:`ACP_CFG_MODE_LSB];
      end
      if (reg_write && reg_addr == `ACP_OFF_COMPARE_HIGH)
        compare_high_q <= reg_wdata;
      if (reg_write && reg_addr == `ACP_OFF_COMPARE_LOW)
        compare_low_q <= reg_wdata;
    end
  end

  // Converter clock source and divider
  acp_clkgen u_clkgen (
    .clk(clk),
    .reset(reset),
    .run(run),
    .low_power_mode(low_power_mode),
    .input_clock_select(input_clock_select_q),
    .clock_divide_select(clock_divide_select_q),
    .alternate_clock(alternate_clock),
    .internal_async_clock(internal_async_clock),
    .converter_clock(converter_clock)
  );

  // Approximation sequencer; any control or setup write aborts it
  acp_sar #(
    .RAW_BITS(RAW_BITS)
  ) u_sar (
    .clk(clk),
    .reset(reset),
    .start(start_q),
    .abort(wr_control || wr_setup || module_off),
    .ten_bit(ten_bit),
    .tick(converter_clock),
    .comparator_high(comparator_high),
    .trial_code(trial_code),
    .sampling(sar_sample_w),
    .done(sar_done),
    .busy(sar_busy)
  );

  // Rounding and compare: a failed compare discards the result
  assign rounded = acp_round(trial_code, ten_bit);
  assign compare_value = ten_bit ? {compare_high_q[1:0], compare_low_q} :
    {2'h0, compare_low_q};
  assign accept = !compare_enable_q || (rounded >= compare_value);

  // Result registers and compare status; an abort leaves them alone
  always @(posedge clk) begin
    if (reset) begin
      result_high_q <= `ACP_RST_BYTE;
      result_low_q <= `ACP_RST_BYTE;
      compare_match_q <= 1'b0;
    end else begin
      if (sar_done && compare_enable_q)
        compare_match_q <= accept;
      if (sar_done && accept) begin
        // Eight-bit mode writes the low byte only
        if (ten_bit)
          result_high_q <= {6'h00, rounded[9:8]};
        result_low_q <= rounded[7:0];
      end
    end
  end

  // Done flag: a new result wins over a clear in the same cycle
  always @(posedge clk) begin
    if (reset)
      conversion_done_flag_q <= 1'b0;
    else if (sar_done && accept)
      conversion_done_flag_q <= 1'b1;
    else if (wr_control || rd_result_low)
      conversion_done_flag_q <= 1'b0;
  end

  // Interrupt request is a level while flag and enable are high
  assign done_irq = conversion_done_flag_q && done_interrupt_enable_q;
  assign compare_match = compare_match_q;

  // Pin disable registers, absent when the channels have no inputs
  always @(posedge clk) begin
    if (reset) begin
      analog_pin_disable_mid_q <= `ACP_RST_PINS;
      analog_pin_disable_high_q <= `ACP_RST_PINS;
    end else if (reg_write) begin
      if (reg_addr == `ACP_OFF_PIN_MID && HAS_MID_PINS != 0)
        analog_pin_disable_mid_q <= reg_wdata;
      if (reg_addr == `ACP_OFF_PIN_HIGH && HAS_HIGH_PINS != 0)
        analog_pin_disable_high_q <= reg_wdata;
    end
  end

  // Bit 0 of each register is its lowest channel
  assign pin_off = {analog_pin_disable_high_q,
    analog_pin_disable_mid_q};

  // Disabled pins: buffer off, input and pullup off, reads zero
  assign pin_out_en_n = port_out_en_n_in | pin_off;
  assign pin_input_en = ~pin_off;
  assign pin_pullup_en = port_pullup_in & ~pin_off;
  assign port_read_value = port_pin_in & ~pin_off;

  // Read multiplexer
  always @* begin
    case (reg_addr)
      `ACP_OFF_CONTROL:
        rdata_d = {conversion_done_flag_q, done_interrupt_enable_q,
          1'b0, channel_select_q};
      `ACP_OFF_STATUS:
        rdata_d = {sar_busy, 3'h0, compare_match_q, compare_enable_q, 2'h0};
      `ACP_OFF_RESULT_HIGH: rdata_d = result_high_q;
      `ACP_OFF_RESULT_LOW: rdata_d = result_low_q;
      `ACP_OFF_COMPARE_HIGH: rdata_d = compare_high_q;
      `ACP_OFF_COMPARE_LOW: rdata_d = compare_low_q;
      `ACP_OFF_CONFIG:
        rdata_d = {1'b0, clock_divide_select_q, 1'b0, mode_q,
          input_clock_select_q};
      `ACP_OFF_PIN_MID: rdata_d = analog_pin_disable_mid_q;
      `ACP_OFF_PIN_HIGH: rdata_d = analog_pin_disable_high_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

//--- rtl/acp_regs.vh
// Register offsets, field positions and reset values of the converter
// control block. Definitions only; included by bare name.
`ifndef ACP_REGS_VH
`define ACP_REGS_VH

// Register offsets on the 4-bit register port
`define ACP_OFF_CONTROL 4'h0
`define ACP_OFF_STATUS 4'h1
`define ACP_OFF_RESULT_HIGH 4'h2
`define ACP_OFF_RESULT_LOW 4'h3
`define ACP_OFF_COMPARE_HIGH 4'h4
`define ACP_OFF_COMPARE_LOW 4'h5
`define ACP_OFF_CONFIG 4'h6
`define ACP_OFF_PIN_MID 4'h7
`define ACP_OFF_PIN_HIGH 4'h8

// Control register fields
`define ACP_CTL_DONE_BIT 7
`define ACP_CTL_IEN_BIT 6
`define ACP_CTL_CH_MSB 4
`define ACP_CTL_CH_LSB 0
`define ACP_CH_DISABLED 5'h1F

// Status register fields
`define ACP_STS_ACTIVE_BIT 7
`define ACP_STS_MATCH_BIT 3
`define ACP_STS_CMPEN_BIT 2

// Configuration register fields
`define ACP_CFG_DIV_MSB 6
`define ACP_CFG_DIV_LSB 5
`define ACP_CFG_MODE_MSB 3
`define ACP_CFG_MODE_LSB 2
`define ACP_CFG_CLK_MSB 1
`define ACP_CFG_CLK_LSB 0

// Field encodings
`define ACP_CLK_BUS 2'h0
`define ACP_CLK_BUS_HALF 2'h1
`define ACP_CLK_ALT 2'h2
`define ACP_CLK_ASYNC 2'h3
`define ACP_MODE_8BIT 2'h0
`define ACP_MODE_10BIT 2'h2

// Reset values
`define ACP_RST_CHANNEL 5'h1F
`define ACP_RST_CONFIG 8'h00
`define ACP_RST_PINS 8'h00
`define ACP_RST_BYTE 8'h00

// Sample count in converter clock ticks and raw code width in bits
`define ACP_SAMPLE_TICKS 4'h4
`define ACP_RAW_BITS 11

`endif

//--- rtl/acp_clkgen.v
// Converter clock source select and divider, producing a one-cycle tick.
// Assumes alternate and internal clocks are slow against clk.
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.vh"

module acp_clkgen (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Control
  input wire run,
  input wire low_power_mode,
  input wire [1:0] input_clock_select,
  input wire [1:0] clock_divide_select,
  // Foreign clocks sampled as pins
  input wire alternate_clock,
  input wire internal_async_clock,
  // Converter clock tick
  output reg converter_clock
);

  reg [2:0] alt_sync_q;
  reg [2:0] async_sync_q;
  reg alt_level_q;
  reg async_level_q;
  reg half_q;
  reg [2:0] div_cnt_q;
  reg src_tick;
  wire [2:0] div_mask;
  wire alt_rise;
  wire async_rise;
  wire src_live;

  // Three-stage samplers; a level counts once stages two and three agree
  always @(posedge clk) begin
    if (reset) begin
      alt_sync_q <= 3'h0;
      async_sync_q <= 3'h0;
      alt_level_q <= 1'b0;
      async_level_q <= 1'b0;
    end else begin
      alt_sync_q <= {alt_sync_q[1:0], alternate_clock};
      async_sync_q <= {async_sync_q[1:0], internal_async_clock};
      if (alt_sync_q[1] == alt_sync_q[2])
        alt_level_q <= alt_sync_q[2];
      if (async_sync_q[1] == async_sync_q[2])
        async_level_q <= async_sync_q[2];
    end
  end

  assign alt_rise = alt_sync_q[1] & alt_sync_q[2] & ~alt_level_q;
  assign async_rise = async_sync_q[1] & async_sync_q[2] & ~async_level_q;

  // Only the internal clock keeps running in wait or stop3
  assign src_live = run &
    (~low_power_mode | (input_clock_select == `ACP_CLK_ASYNC));

  // Source select among the four choices
  always @* begin
    case (input_clock_select)
      `ACP_CLK_BUS: src_tick = 1'b1;
      `ACP_CLK_BUS_HALF: src_tick = half_q;
      `ACP_CLK_ALT: src_tick = alt_rise;
      `ACP_CLK_ASYNC: src_tick = async_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // Divide by 1, 2, 4 or 8
  assign div_mask = (3'h1 << clock_divide_select) - 3'h1;

  // Half-rate toggle and divider counter
  always @(posedge clk) begin
    if (reset || !src_live) begin
      half_q <= 1'b0;
      div_cnt_q <= 3'h0;
      converter_clock <= 1'b0;
    end else begin
      half_q <= ~half_q;
      converter_clock <= 1'b0;
      if (src_tick) begin
        if (div_cnt_q >= div_mask) begin
          div_cnt_q <= 3'h0;
          converter_clock <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 3'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/acp_sar.v
// Successive-approximation sequencer stepped by the converter tick.
// Assumes the analog comparator answer is valid by the next tick.
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.vh"

module acp_sar #(
  parameter RAW_BITS = `ACP_RAW_BITS
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Control
  input wire start,
  input wire abort,
  input wire ten_bit,
  input wire tick,
  // Analog core
  input wire comparator_high,
  output reg [RAW_BITS-1:0] trial_code,
  output reg sampling,
  // Result
  output reg done,
  output reg busy
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_BITS = 2'h2;
  // Index of the first trial bit, cut to the counter's width
  localparam [31:0] TOP_COUNT = RAW_BITS - 1;

  reg [1:0] state_q;
  reg [3:0] count_q;
  reg [RAW_BITS-1:0] probe_q;
  wire [3:0] last_bit;

  // 11 trial bits in 10-bit mode, 9 in 8-bit mode, left aligned
  assign last_bit = ten_bit ? 4'h0 : 4'h2;

  // Sample phase, then one trial bit per tick
  always @(posedge clk) begin
    if (reset || abort) begin
      state_q <= ST_IDLE;
      count_q <= 4'h0;
      probe_q <= {RAW_BITS{1'b0}};
      trial_code <= {RAW_BITS{1'b0}};
      sampling <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_SAMPLE;
            count_q <= `ACP_SAMPLE_TICKS;
            sampling <= 1'b1;
            busy <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (count_q == 4'h1) begin
              state_q <= ST_BITS;
              sampling <= 1'b0;
              count_q <= TOP_COUNT[3:0];
              probe_q <= {1'b1, {(RAW_BITS-1){1'b0}}};
              trial_code <= {1'b1, {(RAW_BITS-1){1'b0}}};
            end else begin
              count_q <= count_q - 4'h1;
            end
          end
        end
        ST_BITS: begin
          if (tick) begin
            if (!comparator_high)
              trial_code <= (trial_code & ~probe_q) | (probe_q >> 1);
            else
              trial_code <= trial_code | (probe_q >> 1);
            probe_q <= probe_q >> 1;
            if (count_q == last_bit) begin
              if (!comparator_high)
                trial_code <= trial_code & ~probe_q;
              else
                trial_code <= trial_code;
              state_q <= ST_IDLE;
              done <= 1'b1;
              busy <= 1'b0;
            end else begin
              count_q <= count_q - 4'h1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/acp_chk.sv
// Port-level assertions for the converter control top.
// Bound to every acp_top instance; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module acp_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  // Converter side
  input wire logic [4:0] analog_channel,
  input wire logic converter_power_on,
  input wire logic async_clock_enable,
  input wire logic done_irq,
  // Pin side
  input wire logic [15:0] port_read_value,
  input wire logic [15:0] pin_out_en_n,
  input wire logic [15:0] pin_pullup_en,
  input wire logic [15:0] pin_input_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Register requests that start or change a conversion
  sequence s_ctl_wr;
    reg_write && reg_addr == 4'h0;
  endsequence
  sequence s_cfg_wr;
    reg_write && reg_addr == 4'h6;
  endsequence
  // Result read that cannot meet a conversion finishing this cycle
  sequence s_idle_low_rd;
    reg_read && reg_addr == 4'h3 && !converter_power_on &&
      !$past(converter_power_on);
  endsequence
  chk_pin_read_zero: assert property (
    (port_read_value & ~pin_input_en) == 16'h0000)
    else $error("disabled pin does not read zero");
  chk_pin_hiz: assert property (
    (pin_out_en_n | pin_input_en) == 16'hFFFF)
    else $error("disabled pin output not high impedance");
  chk_pin_pullup: assert property (
    (pin_pullup_en & ~pin_input_en) == 16'h0000)
    else $error("disabled pin keeps its pull-up");
  chk_chan_follow: assert property (
    s_ctl_wr |=> analog_channel == $past(reg_wdata[4:0]))
    else $error("channel field not taken from write");
  chk_off_disabled: assert property (
    analog_channel == 5'h1F && $past(analog_channel) == 5'h1F
    |-> !converter_power_on)
    else $error("converter on with all-ones channel");
  chk_async_only_run: assert property (
    async_clock_enable |-> converter_power_on)
    else $error("internal clock on while idle");
  chk_cfg_abort_idle: assert property (
    s_cfg_wr |=> ##[0:1] !converter_power_on)
    else $error("config write did not return to idle");
  chk_done_clear: assert property (
    s_idle_low_rd |=> !done_irq)
    else $error("result read did not clear done");
  chk_done_cause: assert property (
    $rose(done_irq) |-> $past(converter_power_on)
    || $past(converter_power_on, 2))
    else $error("done raised without a conversion");
endmodule
bind acp_top acp_chk u_chk (.clk, .reset, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .analog_channel, .converter_power_on,
  .async_clock_enable, .done_irq, .port_read_value, .pin_out_en_n,
  .pin_pullup_en, .pin_input_en);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the converter control top.
// Drives all ports itself; the analog core answers with a fixed level.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic low_power_mode = 1'b0;
  logic alternate_clock = 1'b0;
  logic internal_async_clock = 1'b0;
  logic comparator_high = 1'b1;
  logic [15:0] port_pin_in = 16'hFFFF;
  logic [15:0] port_out_en_n_in = 16'h0000;
  logic [15:0] port_pullup_in = 16'hFFFF;
  logic [7:0] reg_rdata;
  logic [10:0] trial_code;
  logic [4:0] analog_channel;
  logic sample_enable, converter_power_on, async_clock_enable;
  logic done_irq, compare_match;
  logic [15:0] port_read_value, pin_out_en_n, pin_pullup_en, pin_input_en;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  acp_top dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .low_power_mode, .alternate_clock,
    .internal_async_clock, .comparator_high, .trial_code,
    .sample_enable, .analog_channel, .converter_power_on,
    .async_clock_enable, .done_irq, .compare_match, .port_pin_in,
    .port_out_en_n_in, .port_pullup_in, .port_read_value,
    .pin_out_en_n, .pin_pullup_en, .pin_input_en);
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Slow foreign clocks: periods of 8 and 12 cycles; hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) alternate_clock <= ~alternate_clock;
    if (cyc % 6 == 5) internal_async_clock <= ~internal_async_clock;
    if (cyc == 60000) begin
      bad_count++;
      stop_test;
    end
  end
  // Verdict and end of run
  task stop_test;
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Value compare
  task chk(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycle count compare
  task chk_range(input int n, input int lo, input int hi);
    n_tests++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask
  // One-cycle register write
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // One-cycle read; data stands only in the following cycle
  task rd(input [3:0] a, input [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Waits for done; t ticks (4 sample plus trial bits) of p cycles
  task wait_done(input int p, input int t);
    int n;
    n = 0;
    // Let a clear made at the start edge settle before looking
    #1;
    while (done_irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_range(n, (t - 1) * p, (t + 1) * p + 10);
  endtask
  // Configure, start channel 3 with interrupt enabled, await done
  task run(input [7:0] cfg, input int p, input int t, input c);
    @(posedge clk);
    comparator_high <= c;
    wr(4'h6, cfg);
    wr(4'h0, 8'h43);
    wait_done(p, t);
  endtask
  task t_reset;
    rd(4'h0, 8'h1F);
    rd(4'h6, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'h8, 8'h00);
    chk(converter_power_on, 1'b0);
  endtask
  task t_pins;
    wr(4'h7, 8'hA5);
    wr(4'h8, 8'h3C);
    rd(4'h7, 8'hA5);
    rd(4'h8, 8'h3C);
    chk(pin_out_en_n, 16'h3CA5);
    chk(port_read_value, 16'hC35A);
    chk(pin_pullup_en, 16'hC35A);
    chk(pin_input_en, 16'hC35A);
    @(posedge clk);
    port_out_en_n_in <= 16'h0F0F;
    @(posedge clk);
    #1;
    chk(pin_out_en_n, 16'h3FAF);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    #1;
    chk(pin_input_en, 16'hFFFF);
  endtask
  task t_modes;
    run(8'h08, 1, 15, 1'b1);
    chk(trial_code, 16'h07FF);
    chk(converter_power_on, 1'b0);
    rd(4'h0, 8'hC3);
    rd(4'h2, 8'h03);
    rd(4'h3, 8'hFF);
    chk(done_irq, 1'b0);
    run(8'h00, 1, 13, 1'b1);
    chk(trial_code, 16'h07FC);
    rd(4'h2, 8'h03);
    rd(4'h3, 8'hFF);
    run(8'h04, 1, 13, 1'b0);
    chk(trial_code, 16'h0000);
    rd(4'h2, 8'h03);
    rd(4'h3, 8'h00);
    run(8'h0C, 1, 15, 1'b1);
    rd(4'h2, 8'h03);
  endtask
  task t_irq_off;
    wr(4'h0, 8'h03);
    repeat (40) @(posedge clk);
    #1;
    chk(done_irq, 1'b0);
    rd(4'h0, 8'h83);
    rd(4'h3, 8'hFF);
    rd(4'h0, 8'h03);
  endtask
  task t_compare;
    wr(4'h1, 8'h04);
    wr(4'h4, 8'h03);
    wr(4'h5, 8'hFF);
    run(8'h08, 1, 15, 1'b1);
    chk(compare_match, 1'b1);
    rd(4'h1, 8'h0C);
    @(posedge clk);
    comparator_high <= 1'b0;
    wr(4'h0, 8'h43);
    repeat (40) @(posedge clk);
    #1;
    chk(done_irq, 1'b0);
    chk(trial_code, 16'h0000);
    chk(compare_match, 1'b0);
    chk(converter_power_on, 1'b0);
    rd(4'h3, 8'hFF);
    wr(4'h1, 8'h00);
  endtask
  task t_clocks;
    int b[4] = '{1, 2, 8, 12};
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        run({1'b0, d[1:0], 3'b010, s[1:0]}, b[s] << d, 15, 1'b1);
      end
    end
  endtask
  task t_low_power;
    @(posedge clk);
    low_power_mode <= 1'b1;
    wr(4'h6, 8'h08);
    wr(4'h0, 8'h43);
    repeat (200) @(posedge clk);
    #1;
    chk(done_irq, 1'b0);
    chk(async_clock_enable, 1'b0);
    chk(sample_enable, 1'b1);
    wr(4'h6, 8'h0B);
    wr(4'h0, 8'h43);
    @(posedge clk);
    #1;
    chk(async_clock_enable, 1'b1);
    wait_done(12, 15);
    @(posedge clk);
    low_power_mode <= 1'b0;
  endtask
  task t_off;
    wr(4'h6, 8'h08);
    wr(4'h0, 8'h43);
    wr(4'h0, 8'h5F);
    repeat (40) @(posedge clk);
    #1;
    chk(converter_power_on, 1'b0);
    chk(done_irq, 1'b0);
    chk(analog_channel, 5'h1F);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_pins;
    t_modes;
    t_irq_off;
    t_compare;
    t_clocks;
    t_low_power;
    t_off;
    stop_test;
  end
endmodule
`default_nettype wire
